// >>> hdl/pin_ctrl_pkg.sv
// constants and register map of the code fetch and breakpoint pin block
//
// Contract
// - fetch strobe low for external code fetches
// - low code range internal unless select high
// - breakpoint output high on enabled address match
// - pulse mode gives eight-cycle high pulse
// - latched mode holds until status written one
// - clock output divided, defaults to slowest rate
// - clock output tristate from control bit one
// - port A config bit zero picks pin role
// - irq0 active low, edge or level
// - low reset clears all logic but pin 0 sync and history (set high) and divider count (set to one)
// - data bus driven only in accesses, low suspended
package pin_ctrl_pkg;
    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CADDR_W = 16;
    localparam int GPIO_W = 1;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CPU_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_BP_CTRL = 4'h1;
    localparam logic [ADDR_W-1:0] REG_BP_ADDR_HI = 4'h2;
    localparam logic [ADDR_W-1:0] REG_BP_ADDR_LO = 4'h3;
    localparam logic [ADDR_W-1:0] REG_PA_CFG = 4'h4;
    localparam logic [ADDR_W-1:0] REG_PA_OUT = 4'h5;
    localparam logic [ADDR_W-1:0] REG_PA_OE = 4'h6;
    localparam logic [ADDR_W-1:0] REG_PA_IN = 4'h7;
    localparam logic [ADDR_W-1:0] REG_IRQ_CTRL = 4'h8;
    localparam logic [ADDR_W-1:0] REG_INT_STAT = 4'h9;
    localparam logic [ADDR_W-1:0] REG_INT_MASK = 4'ha;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CPU_CLK_TRI_BIT = 1;
    localparam int CPU_SPD_LSB = 3;
    localparam int CPU_SPD_W = 2;
    localparam int BP_STATUS_BIT = 0;
    localparam int BP_ENABLE_BIT = 1;
    localparam int BP_PULSE_BIT = 2;
    localparam int PA_EXT_IRQ0_N_SEL_BIT = 0;
    localparam int PA_PIN_BIT = 0;
    localparam int IRQ0_EDGE_BIT = 0;
    localparam int INT_BP_BIT = 0;
    localparam int INT_IRQ0_BIT = 1;
    localparam int INT_W = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] CPU_CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] REG_RST = 8'h00;
    localparam logic [CADDR_W-1:0] CADDR_RST = 16'h0000;
    localparam logic [INT_W-1:0] INT_RST = 2'h0;

    // ------------------------------------------------------------
    // code space and timing
    // ------------------------------------------------------------
    localparam logic [CADDR_W-1:0] INT_CODE_TOP = 16'h1fff;
    localparam int CLK_PERIOD_NS = 50;
    localparam int BP_PULSE_CYCLES = 8;
    localparam int PULSE_CNT_W = 4;
    localparam logic [PULSE_CNT_W-1:0] PULSE_LOAD = PULSE_CNT_W'(BP_PULSE_CYCLES);
    localparam logic [PULSE_CNT_W-1:0] PULSE_ZERO = 4'h0;

    // clock output speed codes and their half periods in clk_i cycles
    localparam logic [CPU_SPD_W-1:0] SPD_12 = 2'h0;
    localparam logic [CPU_SPD_W-1:0] SPD_24 = 2'h1;
    localparam logic [CPU_SPD_W-1:0] SPD_48 = 2'h2;
    localparam int DIV_W = 3;
    localparam logic [DIV_W-1:0] HALF_12 = 3'h4;
    localparam logic [DIV_W-1:0] HALF_24 = 3'h2;
    localparam logic [DIV_W-1:0] HALF_48 = 3'h1;
    localparam logic [DIV_W-1:0] DIV_ONE = 3'h1;
endpackage

// >>> hdl/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] sync_o
);
    // ------------------------------------------------------------
    // per-bit chain
    // ------------------------------------------------------------
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        logic s1_r;
        logic s2_r;
        logic s3_r;
        logic out_r;
        // first stage feeds only the second, avoiding metastable fan-out
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                s1_r <= RST_VAL[b];
                s2_r <= RST_VAL[b];
                s3_r <= RST_VAL[b];
            end else begin
                s1_r <= pin_i[b];
                s2_r <= s1_r;
                s3_r <= s2_r;
            end
        end
        // a change counts once stages two and three agree
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                out_r <= RST_VAL[b];
            end else if (s2_r == s3_r) begin
                out_r <= s3_r;
            end
        end
        assign sync_o[b] = out_r;
    end
endmodule

// >>> hdl/code_fetch_breakpoint_pins.sv
// fetch strobe, breakpoint, clock output, port pin and data bus control
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module code_fetch_breakpoint_pins (
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [pin_ctrl_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [pin_ctrl_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [pin_ctrl_pkg::DATA_W-1:0] reg_rdata_o,
    output logic irq_o,
    // processor bus
    input wire logic [pin_ctrl_pkg::CADDR_W-1:0] cpu_addr_i,
    input wire logic cpu_addr_valid_i,
    input wire logic cpu_code_fetch_i,
    input wire logic cpu_data_access_i,
    input wire logic cpu_data_wr_i,
    input wire logic [pin_ctrl_pkg::DATA_W-1:0] cpu_wdata_i,
    input wire logic suspend_i,
    input wire logic irq0_ack_i,
    output logic code_from_ext_o,
    output logic [pin_ctrl_pkg::DATA_W-1:0] ext_rdata_o,
    output logic irq0_req_o,
    // pins
    input wire logic ext_code_select_i,
    output logic prog_fetch_strobe_n_o,
    output logic bp_hit_out_o,
    output logic cpu_clock_out_o,
    output logic cpu_clock_out_oe_o,
    input wire logic porta_pin0_i,
    output logic porta_pin0_o,
    output logic porta_pin0_oe_o,
    input wire logic [pin_ctrl_pkg::DATA_W-1:0] ext_data_i,
    output logic [pin_ctrl_pkg::DATA_W-1:0] ext_data_o,
    output logic ext_data_oe_o
);
    import pin_ctrl_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [DATA_W-1:0] cpu_control_reg_r;
    logic bp_enable_r;
    logic bp_pulse_mode_r;
    logic bp_status_r;
    logic [CADDR_W-1:0] bp_match_addr_r;
    logic porta_alt_config_r;
    logic porta_out_r;
    logic porta_oe_r;
    logic irq0_edge_select_r;
    logic [INT_W-1:0] int_stat_r;
    logic [INT_W-1:0] int_mask_r;
    logic [INT_W-1:0] int_set;
    logic [INT_W-1:0] int_clr;
    logic [DATA_W-1:0] rdata_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic ext_code_select_s;
    logic porta_pin0_s;
    logic pin0_prev_r;
    logic bp_match;
    logic bp_clr;
    logic [PULSE_CNT_W-1:0] pulse_cnt_r;
    logic irq0_latch_r;
    logic irq0_fall;
    logic [DIV_W-1:0] div_cnt_r;
    logic [DIV_W-1:0] half_per;
    logic clk_out_r;
    logic [DATA_W-1:0] ext_data_r;
    logic ext_data_oe_r;
    logic [DATA_W-1:0] ext_rdata_r;
    logic wr_bp;
    logic wr_stat;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // both pins come from outside, so they pass the agreement filter
    pin_sync3 #(.WIDTH(2), .RST_VAL(2'h2)) u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .pin_i({porta_pin0_i, ext_code_select_i}),
        .sync_o({porta_pin0_s, ext_code_select_s})
    );

    // ------------------------------------------------------------
    // code fetch routing
    // ------------------------------------------------------------
    // low range source select
    assign code_from_ext_o = ext_code_select_s || (cpu_addr_i > INT_CODE_TOP);
    assign prog_fetch_strobe_n_o = !(cpu_code_fetch_i && code_from_ext_o);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    assign wr_bp = reg_wr_i && (reg_addr_i == REG_BP_CTRL);
    assign wr_stat = reg_wr_i && (reg_addr_i == REG_INT_STAT);

    // every control register clears on reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cpu_control_reg_r <= CPU_CTRL_RST;
            bp_enable_r <= 1'b0;
            bp_pulse_mode_r <= 1'b0;
            bp_match_addr_r <= CADDR_RST;
            porta_alt_config_r <= 1'b0;
            porta_out_r <= 1'b0;
            porta_oe_r <= 1'b0;
            irq0_edge_select_r <= 1'b0;
            int_mask_r <= INT_RST;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                REG_CPU_CTRL: cpu_control_reg_r <= reg_wdata_i;
                REG_BP_CTRL: begin
                    bp_enable_r <= reg_wdata_i[BP_ENABLE_BIT];
                    bp_pulse_mode_r <= reg_wdata_i[BP_PULSE_BIT];
                end
                REG_BP_ADDR_HI: bp_match_addr_r[CADDR_W-1:DATA_W] <= reg_wdata_i;
                REG_BP_ADDR_LO: bp_match_addr_r[DATA_W-1:0] <= reg_wdata_i;
                REG_PA_CFG: porta_alt_config_r <= reg_wdata_i[PA_EXT_IRQ0_N_SEL_BIT];
                REG_PA_OUT: porta_out_r <= reg_wdata_i[PA_PIN_BIT];
                REG_PA_OE: porta_oe_r <= reg_wdata_i[PA_PIN_BIT];
                REG_IRQ_CTRL: irq0_edge_select_r <= reg_wdata_i[IRQ0_EDGE_BIT];
                REG_INT_MASK: int_mask_r <= reg_wdata_i[INT_W-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // breakpoint
    // ------------------------------------------------------------
    // full 16-bit compare each address cycle
    assign bp_match = bp_enable_r && cpu_addr_valid_i && (cpu_addr_i == bp_match_addr_r);
    assign bp_clr = wr_bp && reg_wdata_i[BP_STATUS_BIT];

    // status set on match, a match beats a clear
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bp_status_r <= 1'b0;
        end else if (bp_match) begin
            bp_status_r <= 1'b1;
        end else if (bp_clr) begin
            bp_status_r <= 1'b0;
        end
    end

    // pulse counter, a fresh match restarts the pulse
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pulse_cnt_r <= PULSE_ZERO;
        end else if (bp_match && bp_pulse_mode_r) begin
            pulse_cnt_r <= PULSE_LOAD;
        end else if (pulse_cnt_r != PULSE_ZERO) begin
            pulse_cnt_r <= pulse_cnt_r - 1'b1;
        end
    end

    // latched mode follows the sticky status
    assign bp_hit_out_o = bp_pulse_mode_r ? (pulse_cnt_r != PULSE_ZERO) : bp_status_r;

    // ------------------------------------------------------------
    // clock output
    // ------------------------------------------------------------
    // no pll here: rates are divisions of clk_i in the documented ratios
    always_comb begin
        case (cpu_control_reg_r[CPU_SPD_LSB +: CPU_SPD_W])
            SPD_24: half_per = HALF_24;
            SPD_48: half_per = HALF_48;
            default: half_per = HALF_12;
        endcase
    end

    // divider, reset loads a count of one; the control register reset value selects the slowest rate
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_cnt_r <= DIV_ONE;
            clk_out_r <= 1'b0;
        end else if (div_cnt_r >= half_per) begin
            div_cnt_r <= DIV_ONE;
            clk_out_r <= !clk_out_r;
        end else begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end
    assign cpu_clock_out_o = clk_out_r;
    assign cpu_clock_out_oe_o = !cpu_control_reg_r[CPU_CLK_TRI_BIT];

    // ------------------------------------------------------------
    // port A pin 0 and irq0
    // ------------------------------------------------------------
    // alternate role turns the pin into an input
    assign porta_pin0_o = porta_out_r;
    assign porta_pin0_oe_o = porta_oe_r && !porta_alt_config_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin0_prev_r <= 1'b1;
        end else begin
            pin0_prev_r <= porta_pin0_s;
        end
    end
    assign irq0_fall = porta_alt_config_r && pin0_prev_r && !porta_pin0_s;

    // edge latch, a new edge wins over an acknowledge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq0_latch_r <= 1'b0;
        end else if (irq0_fall && irq0_edge_select_r) begin
            irq0_latch_r <= 1'b1;
        end else if (irq0_ack_i || !irq0_edge_select_r) begin
            irq0_latch_r <= 1'b0;
        end
    end
    // level mode follows the low pin
    assign irq0_req_o = irq0_edge_select_r ? irq0_latch_r : (porta_alt_config_r && !porta_pin0_s);

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    assign int_set = {irq0_fall, bp_match};
    assign int_clr = wr_stat ? reg_wdata_i[INT_W-1:0] : INT_RST;

    // set beats the write-one clear in the same cycle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_stat_r <= INT_RST;
        end else begin
            int_stat_r <= int_set | (int_stat_r & ~int_clr);
        end
    end
    assign irq_o = |(int_stat_r & int_mask_r);

    // ------------------------------------------------------------
    // external data bus
    // ------------------------------------------------------------
    // drive for writes, low in suspend, released otherwise
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_data_r <= REG_RST;
            ext_data_oe_r <= 1'b0;
        end else if (suspend_i) begin
            ext_data_r <= REG_RST;
            ext_data_oe_r <= 1'b1;
        end else begin
            ext_data_r <= cpu_wdata_i;
            ext_data_oe_r <= cpu_data_access_i && cpu_data_wr_i;
        end
    end
    assign ext_data_o = ext_data_r;
    assign ext_data_oe_o = ext_data_oe_r;

    // capture read data during external reads
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_rdata_r <= REG_RST;
        end else if (cpu_data_access_i && !cpu_data_wr_i && !suspend_i) begin
            ext_rdata_r <= ext_data_i;
        end
    end
    assign ext_rdata_o = ext_rdata_r;

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    // unmapped indices read zero
    always_comb begin
        rdata_nxt = REG_RST;
        case (reg_addr_i)
            REG_CPU_CTRL: rdata_nxt = cpu_control_reg_r;
            REG_BP_CTRL: begin
                rdata_nxt[BP_STATUS_BIT] = bp_status_r;
                rdata_nxt[BP_ENABLE_BIT] = bp_enable_r;
                rdata_nxt[BP_PULSE_BIT] = bp_pulse_mode_r;
            end
            REG_BP_ADDR_HI: rdata_nxt = bp_match_addr_r[CADDR_W-1:DATA_W];
            REG_BP_ADDR_LO: rdata_nxt = bp_match_addr_r[DATA_W-1:0];
            REG_PA_CFG: rdata_nxt[PA_EXT_IRQ0_N_SEL_BIT] = porta_alt_config_r;
            REG_PA_OUT: rdata_nxt[PA_PIN_BIT] = porta_out_r;
            REG_PA_OE: rdata_nxt[PA_PIN_BIT] = porta_oe_r;
            REG_PA_IN: rdata_nxt[PA_PIN_BIT] = porta_pin0_s;
            REG_IRQ_CTRL: rdata_nxt[IRQ0_EDGE_BIT] = irq0_edge_select_r;
            REG_INT_STAT: rdata_nxt[INT_W-1:0] = int_stat_r;
            REG_INT_MASK: rdata_nxt[INT_W-1:0] = int_mask_r;
            default: rdata_nxt = REG_RST;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= REG_RST;
        end else begin
            rdata_r <= reg_rd_i ? rdata_nxt : REG_RST;
        end
    end
    assign reg_rdata_o = rdata_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_FETCH_HIGH: assert property (
        cpu_code_fetch_i && (cpu_addr_i > INT_CODE_TOP) |-> !prog_fetch_strobe_n_o)
        else $error("high code fetch without strobe");

    AST_FETCH_LOW: assert property (
        cpu_code_fetch_i && (cpu_addr_i <= INT_CODE_TOP) |-> (prog_fetch_strobe_n_o == !ext_code_select_s))
        else $error("low code fetch routed wrongly");

    AST_BP_MATCH: assert property (
        cpu_addr_valid_i && bp_enable_r && (cpu_addr_i == bp_match_addr_r) |=> bp_status_r)
        else $error("breakpoint match not recorded");

    AST_BP_PULSE: assert property (
        bp_match && bp_pulse_mode_r && !wr_bp ##1 (!bp_match && !wr_bp) [*8] |=> !bp_hit_out_o
            && $past(bp_hit_out_o, 1) && $past(bp_hit_out_o, 2) && $past(bp_hit_out_o, 3) && $past(bp_hit_out_o, 4)
            && $past(bp_hit_out_o, 5) && $past(bp_hit_out_o, 6) && $past(bp_hit_out_o, 7) && $past(bp_hit_out_o, 8))
        else $error("breakpoint pulse not eight cycles");

    AST_BP_HOLD: assert property (
        !bp_pulse_mode_r && bp_status_r && !bp_clr |=> bp_status_r && (bp_hit_out_o || bp_pulse_mode_r))
        else $error("latched breakpoint dropped");

    AST_BP_CLEAR: assert property (
        bp_clr && !bp_match |=> !bp_status_r)
        else $error("breakpoint status not cleared");

    AST_CLK_FAST: assert property (
        (cpu_control_reg_r[CPU_SPD_LSB +: CPU_SPD_W] == SPD_48) && $stable(cpu_control_reg_r)
            && (div_cnt_r == DIV_ONE) |=> cpu_clock_out_o != $past(cpu_clock_out_o))
        else $error("fast clock output not toggling");

    AST_CLK_TRI: assert property (
        cpu_control_reg_r[CPU_CLK_TRI_BIT] |-> !cpu_clock_out_oe_o)
        else $error("clock output driven while tristated");

    AST_PA0_ROLE: assert property (
        porta_alt_config_r |-> !porta_pin0_oe_o)
        else $error("pin driven in interrupt role");

    AST_IRQ0_LEVEL: assert property (
        porta_alt_config_r && !irq0_edge_select_r |-> (irq0_req_o == !porta_pin0_s))
        else $error("level irq0 mismatch");

    AST_IRQ0_EDGE: assert property (
        irq0_edge_select_r && $fell(porta_pin0_s) && porta_alt_config_r |=> irq0_req_o)
        else $error("edge irq0 not latched");

    AST_DATA_IDLE: assert property (
        !suspend_i && !(cpu_data_access_i && cpu_data_wr_i) |=> !ext_data_oe_o)
        else $error("data bus driven outside access");

    AST_DATA_SUSP: assert property (
        suspend_i |=> ext_data_oe_o && (ext_data_o == REG_RST))
        else $error("data bus not low in suspend");
endmodule

// >>> dv/ext_mem_model.sv
// external memory model on the device data bus
`timescale 1ns/1ps
module ext_mem_model (
    input wire logic clk_i,
    input wire logic [pin_ctrl_pkg::CADDR_W-1:0] addr_i,
    input wire logic rd_i,
    input wire logic oe_i,
    input wire logic [pin_ctrl_pkg::DATA_W-1:0] dev_data_i,
    output logic [pin_ctrl_pkg::DATA_W-1:0] bus_o
);
    import pin_ctrl_pkg::*;
    logic [DATA_W-1:0] last_r = 8'h00;
    // bus ownership: device, memory or nobody
    // no keeper on the lines, so a released bus shows the inverted last value
    assign bus_o = oe_i ? dev_data_i : (rd_i ? (addr_i[7:0] ^ 8'h5a) : ~last_r);
    always_ff @(posedge clk_i) begin
        last_r <= bus_o;
    end
endmodule

// >>> dv/tb_code_fetch_breakpoint_pins.sv
// self-checking bench for the fetch, breakpoint and pin block
`timescale 1ns/1ps
module tb_code_fetch_breakpoint_pins;
    import pin_ctrl_pkg::*;
    logic clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, cpu_addr_valid_i = 0, cpu_code_fetch_i = 0;
    logic cpu_data_access_i = 0, cpu_data_wr_i = 0, suspend_i = 0, irq0_ack_i = 0, ext_code_select_i = 0;
    logic porta_pin0_i = 1, rd_q = 0, f, e;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00, cpu_wdata_i = 8'h00, d;
    logic [15:0] cpu_addr_i = 16'h0000, a, bpa;
    logic [7:0] reg_rdata_o, ext_rdata_o, ext_data_o, ext_data_i;
    logic irq_o, code_from_ext_o, irq0_req_o, prog_fetch_strobe_n_o, bp_hit_out_o, cpu_clock_out_o;
    logic cpu_clock_out_oe_o, porta_pin0_o, porta_pin0_oe_o, ext_data_oe_o;
    int fail_count = 0, compares = 0, seed = 9, n;
    logic [7:0] exp_q[$];
    code_fetch_breakpoint_pins code_fetch_breakpoint_pins_inst (.clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o, .cpu_addr_i, .cpu_addr_valid_i, .cpu_code_fetch_i,
        .cpu_data_access_i, .cpu_data_wr_i, .cpu_wdata_i, .suspend_i, .irq0_ack_i, .code_from_ext_o,
        .ext_rdata_o, .irq0_req_o, .ext_code_select_i, .prog_fetch_strobe_n_o, .bp_hit_out_o,
        .cpu_clock_out_o, .cpu_clock_out_oe_o, .porta_pin0_i, .porta_pin0_o, .porta_pin0_oe_o,
        .ext_data_i, .ext_data_o, .ext_data_oe_o);
    ext_mem_model ext_mem_model_inst (.clk_i, .addr_i(cpu_addr_i), .rd_i(cpu_data_access_i & !cpu_data_wr_i),
        .oe_i(ext_data_oe_o), .dev_data_i(ext_data_o), .bus_o(ext_data_i));
    // 20 MHz clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
        compares++;
        if (g !== ex) begin
            $display("unexpected %s: expected %h seen %h", nm, ex, g);
            fail_count++;
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // read data stands only in the cycle after the strobe edge
    always @(posedge clk_i) begin
        if (rd_q && exp_q.size() == 0) chk("read queue", 16'h0001, 16'h0000);
        else if (rd_q) chk("reg_rdata_o", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata_o});
        rd_q <= reg_rd_i;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    // leading edge keeps strobes from being set and cleared in one step
    task automatic wr(input logic [3:0] ad, input logic [7:0] dw);
        @(posedge clk_i);
        reg_addr_i <= ad;
        reg_wdata_i <= dw;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, input logic [7:0] ex);
        exp_q.push_back(ex);
        @(posedge clk_i);
        reg_addr_i <= ad;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
    endtask
    // one address cycle, then high cycles of the pin over a bounded window
    task automatic hit(input logic [15:0] ad, input int ex);
        @(posedge clk_i);
        cpu_addr_i <= ad;
        cpu_addr_valid_i <= 1'b1;
        @(posedge clk_i);
        cpu_addr_valid_i <= 1'b0;
        n = 0;
        repeat (20) @(negedge clk_i) n += int'(bp_hit_out_o === 1'b1);
        chk("bp_hit_out_o cycles", 16'(ex), 16'(n));
    endtask
    // rises of the clock pin in 32 cycles, a whole number of periods
    task automatic rises(input int ex);
        @(negedge clk_i) f = cpu_clock_out_o;
        n = 0;
        repeat (32) @(negedge clk_i) begin
            n += int'(!f && cpu_clock_out_o === 1'b1);
            f = cpu_clock_out_o;
        end
        chk("cpu_clock_out_o rises", 16'(ex), 16'(n));
    endtask
    task automatic pin(input logic lv);
        @(posedge clk_i) porta_pin0_i <= lv;
        cyc(6);
        @(negedge clk_i);
    endtask
    initial begin
        cyc(19);
        @(negedge clk_i);
        chk("reset state", 16'h0008, {cpu_clock_out_oe_o, bp_hit_out_o, ext_data_oe_o, irq_o});
        @(posedge clk_i) rst_b_i <= 1'b1;
        rd(REG_CPU_CTRL, CPU_CTRL_RST);
        rises(4);
        $display("reset and default clock done");
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_i) ext_code_select_i <= s[0];
            cyc(6);
            for (int i = 0; i < 10; i++) begin
                a = (i == 0) ? INT_CODE_TOP : (i == 1) ? 16'h2000 : 16'($random(seed));
                f = (i < 4) ? 1'b1 : 1'($random(seed));
                cpu_addr_i <= a;
                cpu_code_fetch_i <= f;
                @(negedge clk_i);
                e = s[0] | (a > INT_CODE_TOP);
                chk("code_from_ext_o", 16'(e), 16'(code_from_ext_o));
                chk("prog_fetch_strobe_n_o", 16'(!(f & e)), 16'(prog_fetch_strobe_n_o));
                @(posedge clk_i);
            end
        end
        cpu_code_fetch_i <= 1'b0;
        $display("fetch select done");
        bpa = 16'($random(seed));
        wr(REG_BP_ADDR_HI, bpa[15:8]);
        wr(REG_BP_ADDR_LO, bpa[7:0]);
        rd(REG_BP_ADDR_HI, bpa[15:8]);
        wr(REG_BP_CTRL, 8'h04);
        hit(bpa, 0);
        wr(REG_BP_CTRL, 8'h06);
        hit(bpa ^ 16'h0001, 0);
        hit(bpa ^ 16'h0100, 0);
        hit(bpa, 8);
        wr(REG_BP_CTRL, 8'h03);
        wr(REG_INT_STAT, 8'h01);
        hit(bpa, 20);
        rd(REG_BP_CTRL, 8'h03);
        wr(REG_INT_MASK, 8'h01);
        @(negedge clk_i) chk("irq_o", 16'h0001, 16'(irq_o));
        wr(REG_BP_CTRL, 8'h03);
        wr(REG_INT_STAT, 8'h01);
        @(negedge clk_i) chk("bp and irq", 16'h0000, {bp_hit_out_o, irq_o});
        $display("breakpoint done");
        wr(REG_CPU_CTRL, 8'h10);
        rises(16);
        wr(REG_CPU_CTRL, 8'h08);
        rises(8);
        wr(REG_CPU_CTRL, 8'h02);
        @(negedge clk_i) chk("cpu_clock_out_oe_o", 16'h0000, 16'(cpu_clock_out_oe_o));
        wr(REG_CPU_CTRL, 8'h00);
        $display("clock out done");
        wr(REG_PA_OUT, 8'h01);
        wr(REG_PA_OE, 8'h01);
        @(negedge clk_i) chk("porta pin drive", 16'h0003, {porta_pin0_oe_o, porta_pin0_o});
        rd(REG_PA_IN, 8'h01);
        rd(4'hf, 8'h00);
        wr(REG_PA_CFG, 8'h01);
        @(negedge clk_i) chk("porta_pin0_oe_o", 16'h0000, 16'(porta_pin0_oe_o));
        pin(1'b0);
        chk("irq0 level low", 16'h0001, 16'(irq0_req_o));
        pin(1'b1);
        chk("irq0 level high", 16'h0000, 16'(irq0_req_o));
        wr(REG_IRQ_CTRL, 8'h01);
        pin(1'b0);
        pin(1'b1);
        chk("irq0 edge latched", 16'h0001, 16'(irq0_req_o));
        @(posedge clk_i) irq0_ack_i <= 1'b1;
        @(posedge clk_i) irq0_ack_i <= 1'b0;
        @(negedge clk_i) chk("irq0 acked", 16'h0000, 16'(irq0_req_o));
        rd(REG_INT_STAT, 8'h02);
        $display("port pin done");
        a = 16'($random(seed));
        d = 8'($random(seed));
        @(negedge clk_i) chk("ext_data_oe_o idle", 16'h0000, 16'(ext_data_oe_o));
        @(posedge clk_i);
        cpu_addr_i <= a;
        cpu_wdata_i <= d;
        cpu_data_wr_i <= 1'b1;
        cpu_data_access_i <= 1'b1;
        @(posedge clk_i) cpu_data_access_i <= 1'b0;
        @(negedge clk_i) chk("bus write", {8'h01, d}, {7'h00, ext_data_oe_o, ext_data_o});
        @(negedge clk_i) chk("bus release", 16'h0000, 16'(ext_data_oe_o));
        @(posedge clk_i);
        cpu_data_wr_i <= 1'b0;
        cpu_data_access_i <= 1'b1;
        @(posedge clk_i) cpu_data_access_i <= 1'b0;
        @(negedge clk_i) chk("ext_rdata_o", {8'h00, a[7:0] ^ 8'h5a}, {8'h00, ext_rdata_o});
        @(posedge clk_i) suspend_i <= 1'b1;
        @(posedge clk_i);
        @(negedge clk_i) chk("bus suspend", 16'h0100, {7'h00, ext_data_oe_o, ext_data_o});
        @(posedge clk_i) suspend_i <= 1'b0;
        $display("data bus done");
        cyc(3);
        wrap_up();
    end
endmodule
